/* File: hdl/ase_map.svh */
// Purpose: Register map of the execution slice
// Assumes: Byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef ASE_MAP_SVH
`define ASE_MAP_SVH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define ASE_OFS_STATUS    12'h000
`define ASE_OFS_IDX_FLAGS 12'h004
`define ASE_OFS_PTRS      12'h008
`define ASE_OFS_RESULT    12'h00C
`define ASE_OFS_IDX_BASE  12'h080
`define ASE_OFS_ACC_BASE  12'h100
`define ASE_OFS_RAM_BASE  12'h800
// ----------------------------------------------------------------
// Status word fields and index flag fields
// ----------------------------------------------------------------
`define ASE_XM_BIT   0
`define ASE_OM_BIT   2
`define ASE_OF_BIT   4
`define ASE_SF_BIT   5
`define ASE_ZF_BIT   6
`define ASE_CF_BIT   7
`define ASE_TAG_BIT  8
`define ASE_STATUS_RST 16'h0000
`define ASE_RCF_BIT  0
`define ASE_RZF_BIT  1
// ----------------------------------------------------------------
// Datapath constants
// ----------------------------------------------------------------
`define ASE_WORD_STEP 16'h0002
`define ASE_IDX_FIVE  3'h5
`define ASE_MARK_BIT  16
`define ASE_SAT_POS   16'h7FFF
`define ASE_SAT_NEG   16'h8000
`endif

/* File: hdl/ase_pkg.sv */
// Purpose: Types shared by the execution slice and its sequencer
// Assumes: Nothing beyond the command encoding below
// Notes:   Enums carry no explicit codes
package ase_pkg;
	typedef enum logic [2:0] {
		OP_NONE, acc_right_shift_op, acc_string_right_shift_op,
		set_saturation_op, set_marker_op, word_minus_op, minus_byte_op
	} ase_op_t;
	typedef enum logic [1:0] {PTR_KEEP, PTR_INC, PTR_DEC} ase_ptr_t;
	typedef enum logic [1:0] {DST_ACC, DST_PARTNER, DST_INDEX} ase_dst_t;
	typedef enum logic [2:0] {OPD_ACC, OPD_PARTNER, OPD_MEM, OPD_IMM16, OPD_PH, OPD_R5} ase_opd_t;
	typedef enum logic [2:0] {AM_DIRECT, AM_IND, AM_POSTINC, AM_POSTDEC, AM_INDEXED} ase_am_t;
	typedef enum logic {ST_IDLE, ST_STRING} ase_state_t;
endpackage

/* File: hdl/ase_exec.sv */
// Purpose: Shift-right, saturation-mode, marker-set and subtract slice of a 16-bit core
// Assumes: Sequencer issues one command per cycle only while busy is low
// Notes:   Accumulators, index registers and marker RAM live here as flip-flops
//
// Operation
// - Single right shift moves source or partner one bit right into chosen dest.
// - Top bit of a right shift follows the sign-extension mode bit.
// - Requested pointer step happens first, then the new accumulator is read.
// - Accumulator right shift updates overflow, sign, zero and carry flags.
// - String right shift shifts each word alone, nothing crosses word boundaries.
// - Each string word gets its top bit from the sign-extension mode bit.
// - Set-saturation writes one to flags bit 2, leaving other flags alone.
// - Sign-extension mode bit is flags bit 0.
// - Set-marker writes one to the addressed word's marker, any addressing mode.
// - Set-marker touches only bit 16 of the word, data bits unchanged.
// - Marker operand is a byte address; odd addresses drop the low bit.
// - Two operands: dest minus source; three operands: first minus second source.
// - Subtraction is two's complement; carry is the true adder carry out.
// - Subtract into an index register updates index carry and zero only.
// - Memory second source copies its marker bit into the marker flag.
// - Product-high register may be subtracted from an accumulator or partner.
// - Index register five may be subtracted from any index register.
// - Byte subtract takes an 8-bit immediate from accumulator or index register.
// - Word subtract forms may step the accumulator pointer before reading.
// - Index plus register five addressing sums both, modifying neither.
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "ase_map.svh"
module ase_exec #(
	parameter int ACC_WORDS = 32,
	parameter int ACC_OFS   = 16,
	parameter int RAM_WORDS = 64,
	parameter int STR_W     = 4
) (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            reset,
	// Command from the sequencer
	input  wire logic            cmd_valid,
	input  wire ase_pkg::ase_op_t  cmd_op,
	input  wire logic [1:0]      cmd_an,
	input  wire ase_pkg::ase_ptr_t cmd_ptr,
	input  wire ase_pkg::ase_dst_t cmd_dst,
	input  wire logic            cmd_src_partner,
	input  wire logic            cmd_three,
	input  wire ase_pkg::ase_opd_t cmd_minuend,
	input  wire ase_pkg::ase_opd_t cmd_subtrahend,
	input  wire logic [2:0]      cmd_rx,
	input  wire ase_pkg::ase_am_t  cmd_am,
	input  wire logic [15:0]     cmd_imm16,
	input  wire logic [7:0]      cmd_byte_immediate,
	input  wire logic [STR_W-1:0] cmd_str_len,
	input  wire logic [15:0]     ph_value,
	// Register port
	input  wire logic [11:0]     reg_addr,
	input  wire logic [31:0]     reg_wdata,
	input  wire logic            reg_wr,
	input  wire logic            reg_rd,
	output logic      [31:0]     reg_rdata,
	// Status
	output logic                 busy,
	output logic                 op_done,
	output logic      [15:0]     status_word,
	output logic      [1:0]      index_flags
);
	import ase_pkg::*;
	localparam int AAW = $clog2(ACC_WORDS);
	localparam int RAW = $clog2(RAM_WORDS);

	logic [15:0]    acc [ACC_WORDS];
	logic [15:0]    ridx [8];
	logic [16:0]    ram [RAM_WORDS];
	logic [AAW-1:0] ap [4];
	logic [15:0]    last_result;
	ase_state_t     state;
	logic [AAW-1:0] str_src;
	logic [AAW-1:0] str_dst;
	logic [STR_W-1:0] str_cnt;
	logic [STR_W-1:0] str_len;
	logic           str_zero;

	// ----------------------------------------------------------------
	// Operand selection
	// ----------------------------------------------------------------
	logic           go;
	logic [AAW-1:0] next_ap;
	logic [AAW-1:0] base_ix;
	logic [AAW-1:0] part_ix;
	logic [AAW-1:0] dst_ix;
	logic [15:0]    ea;
	logic [RAW-1:0] mem_ix;
	logic [16:0]    mem_word;
	logic           mem_used;
	logic           xm;
	logic           om;

	assign go = cmd_valid && (state == ST_IDLE);
	assign xm = status_word[`ASE_XM_BIT];
	assign om = status_word[`ASE_OM_BIT];

	always_comb begin
		unique case (cmd_ptr)
			PTR_INC: next_ap = ap[cmd_an] + AAW'(1);
			PTR_DEC: next_ap = ap[cmd_an] - AAW'(1);
			default: next_ap = ap[cmd_an];
		endcase
	end
	assign base_ix = next_ap;
	assign part_ix = next_ap + AAW'(ACC_OFS);
	assign dst_ix  = (cmd_dst == DST_PARTNER) ? part_ix : base_ix;

	always_comb begin
		unique case (cmd_am)
			AM_DIRECT:  ea = cmd_imm16;
			AM_INDEXED: ea = ridx[cmd_rx] + ridx[`ASE_IDX_FIVE];
			default:    ea = ridx[cmd_rx];
		endcase
	end
	assign mem_ix   = ea[RAW:1];
	assign mem_word = ram[mem_ix];
	assign mem_used = (cmd_op == set_marker_op) || ((cmd_op == word_minus_op) &&
		(cmd_subtrahend == OPD_MEM || (cmd_three && cmd_minuend == OPD_MEM)));

	function automatic logic [15:0] opd_val(input ase_opd_t sel);
		unique case (sel)
			OPD_ACC:     opd_val = acc[base_ix];
			OPD_PARTNER: opd_val = acc[part_ix];
			OPD_MEM:     opd_val = mem_word[15:0];
			OPD_IMM16:   opd_val = cmd_imm16;
			OPD_PH:      opd_val = ph_value;
			default:     opd_val = ridx[`ASE_IDX_FIVE];
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Arithmetic
	// ----------------------------------------------------------------
	logic [15:0] dst_val;
	logic [15:0] min_val;
	logic [15:0] sub_val;
	logic [16:0] diff;
	logic        sub_ovf;
	logic [15:0] sub_res;
	logic [15:0] shr_src;
	logic [15:0] shr_res;
	logic [15:0] str_word;
	logic [15:0] str_res;

	assign dst_val = (cmd_dst == DST_INDEX) ? ridx[cmd_rx] : acc[dst_ix];
	// Two-operand form reuses the destination as minuend
	assign min_val = (cmd_op == word_minus_op && cmd_three) ? opd_val(cmd_minuend) : dst_val;
	assign sub_val = (cmd_op == minus_byte_op) ? {8'h00, cmd_byte_immediate} : opd_val(cmd_subtrahend);
	// Carry is the adder carry of a + ~b + 1, i.e. set when no borrow occurs
	assign diff    = {1'b0, min_val} + {1'b0, ~sub_val} + 17'h00001;
	assign sub_ovf = (min_val[15] != sub_val[15]) && (diff[15] != min_val[15]);
	always_comb begin
		sub_res = diff[15:0];
		if (om && sub_ovf && cmd_dst != DST_INDEX) begin
			sub_res = min_val[15] ? `ASE_SAT_NEG : `ASE_SAT_POS;
		end
	end

	assign shr_src  = cmd_src_partner ? acc[part_ix] : acc[base_ix];
	assign shr_res  = {xm & shr_src[15], shr_src[15:1]};
	assign str_word = acc[str_src + AAW'(str_cnt)];
	assign str_res  = {xm & str_word[15], str_word[15:1]};

	// ----------------------------------------------------------------
	// String sequencing
	// ----------------------------------------------------------------
	logic str_last;
	assign str_last = (state == ST_STRING) && (str_cnt == str_len);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state    <= ST_IDLE;
			str_src  <= '0;
			str_dst  <= '0;
			str_cnt  <= '0;
			str_len  <= '0;
			str_zero <= 1'b0;
		end else if (go && cmd_op == acc_string_right_shift_op) begin
			state    <= ST_STRING;
			str_src  <= cmd_src_partner ? part_ix : base_ix;
			str_dst  <= dst_ix;
			str_cnt  <= '0;
			str_len  <= cmd_str_len;
			str_zero <= 1'b1;
		end else if (state == ST_STRING) begin
			str_cnt  <= str_cnt + STR_W'(1);
			str_zero <= str_zero && (str_res == 16'h0000);
			if (str_last) begin
				state <= ST_IDLE;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			busy    <= 1'b0;
			op_done <= 1'b0;
		end else begin
			busy    <= (go && cmd_op == acc_string_right_shift_op) || (state == ST_STRING && !str_last);
			op_done <= (go && cmd_op != OP_NONE && cmd_op != acc_string_right_shift_op) || str_last;
		end
	end

	// ----------------------------------------------------------------
	// Register file writes
	// ----------------------------------------------------------------
	logic [9:0] wa;
	logic [9:0] acc_off;
	logic [9:0] idx_off;
	logic [9:0] ram_off;
	logic       acc_hit;
	logic       idx_hit;
	logic       ram_hit;
	assign wa      = reg_addr[11:2];
	assign acc_off = wa - 10'(`ASE_OFS_ACC_BASE >> 2);
	assign idx_off = wa - 10'(`ASE_OFS_IDX_BASE >> 2);
	assign ram_off = wa - 10'(`ASE_OFS_RAM_BASE >> 2);
	assign acc_hit = acc_off < 10'(ACC_WORDS);
	assign idx_hit = idx_off < 10'h008;
	assign ram_hit = ram_off < 10'(RAM_WORDS);

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 4; i++) ap[i] <= '0;
		end else if (go && cmd_ptr != PTR_KEEP) begin
			ap[cmd_an] <= next_ap;
		end else if (reg_wr && reg_addr == `ASE_OFS_PTRS) begin
			for (int i = 0; i < 4; i++) ap[i] <= reg_wdata[8*i +: AAW];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < ACC_WORDS; i++) acc[i] <= 16'h0000;
		end else if (state == ST_STRING) begin
			acc[str_dst + AAW'(str_cnt)] <= str_res;
		end else if (go && cmd_op == acc_right_shift_op) begin
			acc[dst_ix] <= shr_res;
		end else if (go && (cmd_op == word_minus_op || cmd_op == minus_byte_op) && cmd_dst != DST_INDEX) begin
			acc[dst_ix] <= sub_res;
		end else if (reg_wr && acc_hit) begin
			acc[acc_off[AAW-1:0]] <= reg_wdata[15:0];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < 8; i++) ridx[i] <= 16'h0000;
		end else if (go && (cmd_op == word_minus_op || cmd_op == minus_byte_op) && cmd_dst == DST_INDEX) begin
			ridx[cmd_rx] <= diff[15:0];
		end else if (go && mem_used && cmd_am == AM_POSTINC) begin
			ridx[cmd_rx] <= ridx[cmd_rx] + `ASE_WORD_STEP;
		end else if (go && mem_used && cmd_am == AM_POSTDEC) begin
			ridx[cmd_rx] <= ridx[cmd_rx] - `ASE_WORD_STEP;
		end else if (reg_wr && idx_hit) begin
			ridx[idx_off[2:0]] <= reg_wdata[15:0];
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			for (int i = 0; i < RAM_WORDS; i++) ram[i] <= 17'h00000;
		end else if (go && cmd_op == set_marker_op) begin
			ram[mem_ix][`ASE_MARK_BIT] <= 1'b1;
		end else if (reg_wr && ram_hit) begin
			ram[ram_off[RAW-1:0]] <= reg_wdata[16:0];
		end
	end

	// ----------------------------------------------------------------
	// Flags
	// ----------------------------------------------------------------
	logic acc_sub;
	assign acc_sub = go && (cmd_op == word_minus_op || cmd_op == minus_byte_op) && cmd_dst != DST_INDEX;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			status_word <= `ASE_STATUS_RST;
		end else if (go && cmd_op == set_saturation_op) begin
			status_word[`ASE_OM_BIT] <= 1'b1;
		end else if (go && cmd_op == acc_right_shift_op) begin
			status_word[`ASE_OF_BIT] <= 1'b0;
			status_word[`ASE_SF_BIT] <= shr_res[15];
			status_word[`ASE_ZF_BIT] <= shr_res == 16'h0000;
			status_word[`ASE_CF_BIT] <= shr_src[0];
		end else if (str_last) begin
			status_word[`ASE_OF_BIT] <= 1'b0;
			status_word[`ASE_SF_BIT] <= str_res[15];
			status_word[`ASE_ZF_BIT] <= str_zero && (str_res == 16'h0000);
			status_word[`ASE_CF_BIT] <= str_word[0];
		end else if (acc_sub) begin
			status_word[`ASE_OF_BIT] <= sub_ovf;
			status_word[`ASE_SF_BIT] <= sub_res[15];
			status_word[`ASE_ZF_BIT] <= sub_res == 16'h0000;
			status_word[`ASE_CF_BIT] <= diff[16];
			if (cmd_op == word_minus_op && cmd_subtrahend == OPD_MEM) begin
				status_word[`ASE_TAG_BIT] <= mem_word[`ASE_MARK_BIT];
			end
		end else if (reg_wr && reg_addr == `ASE_OFS_STATUS) begin
			status_word <= {7'h00, reg_wdata[8:0]};
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			index_flags <= 2'h0;
		end else if (go && (cmd_op == word_minus_op || cmd_op == minus_byte_op) && cmd_dst == DST_INDEX) begin
			index_flags[`ASE_RCF_BIT] <= diff[16];
			index_flags[`ASE_RZF_BIT] <= diff[15:0] == 16'h0000;
		end else if (reg_wr && reg_addr == `ASE_OFS_IDX_FLAGS) begin
			index_flags <= reg_wdata[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Result capture and register reads
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			last_result <= 16'h0000;
		end else if (go && cmd_op == acc_right_shift_op) begin
			last_result <= shr_res;
		end else if (go && (cmd_op == word_minus_op || cmd_op == minus_byte_op)) begin
			last_result <= (cmd_dst == DST_INDEX) ? diff[15:0] : sub_res;
		end else if (state == ST_STRING) begin
			last_result <= str_res;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reg_rdata <= 32'h00000000;
		end else if (!reg_rd) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_addr == `ASE_OFS_STATUS) begin
			reg_rdata <= {16'h0000, status_word};
		end else if (reg_addr == `ASE_OFS_IDX_FLAGS) begin
			reg_rdata <= {30'h00000000, index_flags};
		end else if (reg_addr == `ASE_OFS_PTRS) begin
			reg_rdata <= {8'(ap[3]), 8'(ap[2]), 8'(ap[1]), 8'(ap[0])};
		end else if (reg_addr == `ASE_OFS_RESULT) begin
			reg_rdata <= {16'h0000, last_result};
		end else if (acc_hit) begin
			reg_rdata <= {16'h0000, acc[acc_off[AAW-1:0]]};
		end else if (idx_hit) begin
			reg_rdata <= {16'h0000, ridx[idx_off[2:0]]};
		end else if (ram_hit) begin
			reg_rdata <= {15'h0000, ram[ram_off[RAW-1:0]]};
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_shr_value;
		@(posedge clk) disable iff (reset)
		(go && cmd_op == acc_right_shift_op) |=>
			last_result == {$past(xm) & $past(shr_src[15]), $past(shr_src[15:1])};
	endproperty
	a_shr_value: assert property (p_shr_value) else $error("right shift result wrong");

	property p_shr_flags;
		@(posedge clk) disable iff (reset)
		(go && cmd_op == acc_right_shift_op) |=> status_word[`ASE_CF_BIT] == $past(shr_src[0])
			&& status_word[`ASE_ZF_BIT] == (last_result == 16'h0000);
	endproperty
	a_shr_flags: assert property (p_shr_flags) else $error("shift flags wrong");

	property p_sat_set;
		@(posedge clk) disable iff (reset)
		(go && cmd_op == set_saturation_op) |=> status_word[`ASE_OM_BIT]
			&& status_word[15:3] == $past(status_word[15:3]) && status_word[1:0] == $past(status_word[1:0]);
	endproperty
	a_sat_set: assert property (p_sat_set) else $error("saturation set disturbed flags");

	property p_marker;
		@(posedge clk) disable iff (reset)
		(go && cmd_op == set_marker_op) |=> ram[$past(mem_ix)] == {1'b1, $past(mem_word[15:0])};
	endproperty
	a_marker: assert property (p_marker) else $error("marker write wrong");

	property p_sub_carry;
		@(posedge clk) disable iff (reset)
		acc_sub |=> status_word[`ASE_CF_BIT] == ($past(min_val) >= $past(sub_val));
	endproperty
	a_sub_carry: assert property (p_sub_carry) else $error("subtract carry wrong");

	property p_idx_flags;
		@(posedge clk) disable iff (reset)
		(go && cmd_op == word_minus_op && cmd_dst == DST_INDEX) |=> $stable(status_word)
			&& index_flags[`ASE_RZF_BIT] == (ridx[$past(cmd_rx)] == 16'h0000);
	endproperty
	a_idx_flags: assert property (p_idx_flags) else $error("index flags wrong");

	property p_string_word;
		@(posedge clk) disable iff (reset)
		(state == ST_STRING) |=> acc[$past(str_dst) + AAW'($past(str_cnt))] == {$past(xm) & $past(str_word[15]),
			$past(str_word[15:1])};
	endproperty
	a_string_word: assert property (p_string_word) else $error("string word shifted wrong");

	property p_post_dec;
		@(posedge clk) disable iff (reset)
		(go && mem_used && cmd_am == AM_POSTDEC && cmd_dst != DST_INDEX) |=>
			ridx[$past(cmd_rx)] == $past(ridx[cmd_rx]) - 16'h0002;
	endproperty
	a_post_dec: assert property (p_post_dec) else $error("post-decrement step wrong");

	property p_pointer;
		@(posedge clk) disable iff (reset)
		(go && cmd_ptr == PTR_INC) |=> ap[$past(cmd_an)] == $past(ap[cmd_an]) + AAW'(1);
	endproperty
	a_pointer: assert property (p_pointer) else $error("pointer step wrong");
endmodule

/* File: bench/ase_seq_model.sv */
// Purpose: Sequencer stand-in for the execution slice
// Assumes: Commands go out only while busy is low
// Notes:   Random idle gap before each command
`timescale 1ns/1ns
module ase_seq_model (
	// Clock and handshake
	input  wire logic          clk,
	input  wire logic          busy,
	input  wire logic          op_done,
	// Command fields
	output logic               cmd_valid,
	output ase_pkg::ase_op_t   cmd_op,
	output logic [1:0]         cmd_an,
	output ase_pkg::ase_ptr_t  cmd_ptr,
	output ase_pkg::ase_dst_t  cmd_dst,
	output logic               cmd_src_partner,
	output logic               cmd_three,
	output ase_pkg::ase_opd_t  cmd_minuend,
	output ase_pkg::ase_opd_t  cmd_subtrahend,
	output logic [2:0]         cmd_rx,
	output ase_pkg::ase_am_t   cmd_am,
	output logic [15:0]        cmd_imm16,
	output logic [7:0]         cmd_byte_immediate,
	output logic [3:0]         cmd_str_len
);
	import ase_pkg::*;
	initial begin
		{cmd_valid, cmd_an, cmd_src_partner, cmd_three, cmd_rx, cmd_imm16, cmd_byte_immediate, cmd_str_len} = '0;
		cmd_op = OP_NONE;
		cmd_ptr = PTR_KEEP;
		cmd_dst = DST_ACC;
		cmd_minuend = OPD_ACC;
		cmd_subtrahend = OPD_ACC;
		cmd_am = AM_DIRECT;
	end
	// One command, then wait for op_done
	task automatic issue(input ase_op_t op, input ase_ptr_t p, input ase_dst_t d, input logic sp, input logic th,
		input ase_opd_t mn, input ase_opd_t sb, input logic [2:0] rx, input ase_am_t am, input logic [15:0] i16,
		input logic [7:0] i8, input logic [3:0] len, output bit ok);
		int n;
		ok = 1'b0;
		repeat ($urandom_range(0, 2)) @(posedge clk);
		while (busy)
			@(posedge clk);
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_ptr <= p;
		cmd_dst <= d;
		cmd_src_partner <= sp;
		cmd_three <= th;
		cmd_minuend <= mn;
		cmd_subtrahend <= sb;
		cmd_rx <= rx;
		cmd_am <= am;
		cmd_imm16 <= i16;
		cmd_byte_immediate <= i8;
		cmd_str_len <= len;
		@(posedge clk);
		cmd_valid <= 1'b0;
		for (n = 0; n < 40 && !ok; n++) begin
			#1;
			ok = (op_done === 1'b1);
			if (!ok)
				@(posedge clk);
		end
	endtask
endmodule

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the execution slice
// Assumes: Register map of ase_map.svh
// Notes:   No pointer wrap is relied on
`timescale 1ns/1ns
`include "ase_map.svh"
module tb_top;
	import ase_pkg::*;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [15:0] ph_value = 16'h0;
	logic [31:0] reg_rdata;
	logic [15:0] status_word, m_st, a, b;
	logic [1:0]  index_flags, cmd_an;
	logic        busy, op_done, cmd_valid, cmd_src_partner, cmd_three;
	ase_op_t     cmd_op;
	ase_ptr_t    cmd_ptr;
	ase_dst_t    cmd_dst;
	ase_opd_t    cmd_minuend, cmd_subtrahend;
	ase_am_t     cmd_am;
	logic [2:0]  cmd_rx;
	logic [15:0] cmd_imm16;
	logic [7:0]  cmd_byte_immediate;
	logic [3:0]  cmd_str_len;
	logic [15:0] q[$];
	logic [17:0] s;
	logic [31:0] v;
	int          err_total = 0, checked = 0, cyc = 0, k, n, src, dst, w, x, y, ap;
	bit          ok;
	always #5 clk = ~clk;
	ase_exec u_dut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_an(cmd_an),
		.cmd_ptr(cmd_ptr), .cmd_dst(cmd_dst), .cmd_src_partner(cmd_src_partner), .cmd_three(cmd_three),
		.cmd_minuend(cmd_minuend), .cmd_subtrahend(cmd_subtrahend), .cmd_rx(cmd_rx), .cmd_am(cmd_am),
		.cmd_imm16(cmd_imm16), .cmd_byte_immediate(cmd_byte_immediate), .cmd_str_len(cmd_str_len), .ph_value(ph_value),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.busy(busy), .op_done(op_done), .status_word(status_word), .index_flags(index_flags));
	ase_seq_model u_seq (.clk(clk), .busy(busy), .op_done(op_done), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
		.cmd_an(cmd_an), .cmd_ptr(cmd_ptr), .cmd_dst(cmd_dst), .cmd_src_partner(cmd_src_partner),
		.cmd_three(cmd_three), .cmd_minuend(cmd_minuend), .cmd_subtrahend(cmd_subtrahend), .cmd_rx(cmd_rx),
		.cmd_am(cmd_am), .cmd_imm16(cmd_imm16), .cmd_byte_immediate(cmd_byte_immediate), .cmd_str_len(cmd_str_len));
	// ----------
	// Bus, compare and model helpers
	// ----------
	task automatic results();
		$display("Comparisons %0d, mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] ad, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [11:0] ad, input logic [31:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= ad;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask
	task automatic go(input ase_op_t op, input ase_ptr_t p, input ase_dst_t d, input logic sp, input logic th,
		input ase_opd_t mn, input ase_opd_t sb, input logic [2:0] rx, input ase_am_t am, input logic [15:0] i16,
		input logic [7:0] i8, input logic [3:0] len);
		u_seq.issue(op, p, d, sp, th, mn, sb, rx, am, i16, i8, len, ok);
		check({31'h0, ok}, 32'h1);
	endtask
	function automatic logic [11:0] ad(input logic [11:0] base, input int i);
		return base + 12'(4 * i);
	endfunction
	// {overflow, carry, difference}
	function automatic logic [17:0] sub(input logic [15:0] m, input logic [15:0] t);
		logic [16:0] r;
		r = {1'b0, m} + {1'b0, ~t} + 17'h1;
		return {(m[15] != t[15]) && (r[15] != m[15]), r};
	endfunction
	function automatic void flags(input logic [15:0] r, input logic of, input logic cf);
		m_st[`ASE_OF_BIT] = of;
		m_st[`ASE_SF_BIT] = r[15];
		m_st[`ASE_ZF_BIT] = (r == 16'h0);
		m_st[`ASE_CF_BIT] = cf;
	endfunction
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end
	// ----------
	// Main sequence
	// ----------
	initial begin
		void'($urandom(32'hDCAC));
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		rd_chk(`ASE_OFS_STATUS, 32'h0);
		rd_chk(12'h7F0, 32'h0);
		m_st = `ASE_STATUS_RST;
		ap = 2;
		wr(`ASE_OFS_PTRS, 32'h2);
		$display("test reset done");
		for (k = 0; k < 4; k++) begin
			m_st[`ASE_XM_BIT] = k[0];
			wr(`ASE_OFS_STATUS, {16'h0, m_st});
			n = k[0] ? ap + 1 : ap - 1;
			src = k[1] ? n + 16 : n;
			dst = k[1] ? n : n + 16;
			v = $urandom;
			wr(ad(`ASE_OFS_ACC_BASE, ap), {16'h0, ~v[15:0]});
			wr(ad(`ASE_OFS_ACC_BASE, src), {16'h0, v[15:0]});
			go(acc_right_shift_op, k[0] ? PTR_INC : PTR_DEC, k[1] ? DST_ACC : DST_PARTNER, k[1], 0, OPD_ACC,
				OPD_ACC, 0, AM_DIRECT, 0, 0, 0);
			ap = n;
			a = {k[0] ? v[15] : 1'b0, v[15:1]};
			flags(a, 1'b0, v[0]);
			rd_chk(ad(`ASE_OFS_ACC_BASE, dst), {16'h0, a});
			check({16'h0, status_word}, {16'h0, m_st});
			rd_chk(`ASE_OFS_PTRS, 32'(ap));
		end
		$display("test shift done");
		for (k = 0; k < 4; k++) begin
			a = $urandom;
			a[0] = (k == 3);
			wr(ad(`ASE_OFS_ACC_BASE, ap + k), {16'h0, a});
			q.push_back({a[15], a[15:1]});
		end
		go(acc_string_right_shift_op, PTR_KEEP, DST_ACC, 0, 0, OPD_ACC, OPD_ACC, 0, AM_DIRECT, 0, 0, 4'h3);
		check({31'h0, busy}, 32'h0);
		flags(q[3], 1'b0, 1'b1);
		m_st[`ASE_ZF_BIT] = ((q[0] | q[1] | q[2] | q[3]) == 16'h0);
		for (k = 0; k < 4; k++)
			rd_chk(ad(`ASE_OFS_ACC_BASE, ap + k), {16'h0, q[k]});
		check({16'h0, status_word}, {16'h0, m_st});
		$display("test string done");
		for (k = 0; k < 10; k++) begin
			v = $urandom;
			a = v[31:16];
			b = (k == 5) ? a : v[15:0];
			dst = ((k % 5) == 1 || (k % 5) == 2) ? ap + 16 : ap + int'(k % 5 == 0);
			wr(ad(`ASE_OFS_ACC_BASE, dst), {16'h0, a});
			case (k % 5)
				0: begin
					go(word_minus_op, PTR_INC, DST_ACC, 0, 0, OPD_ACC, OPD_IMM16, 0, AM_DIRECT, b, 0, 0);
					ap = dst;
				end
				1: begin
					wr(ad(`ASE_OFS_ACC_BASE, ap), {16'h0, b});
					go(word_minus_op, PTR_KEEP, DST_ACC, 0, 1, OPD_PARTNER, OPD_ACC, 0, AM_DIRECT, 0, 0, 0);
					dst = ap;
				end
				2: begin
					ph_value <= b;
					go(word_minus_op, PTR_KEEP, DST_PARTNER, 0, 0, OPD_ACC, OPD_PH, 0, AM_DIRECT, 0, 0, 0);
				end
				3: begin
					w = $urandom_range(1, 63);
					wr(ad(`ASE_OFS_IDX_BASE, 2), 32'(2 * w));
					wr(ad(`ASE_OFS_RAM_BASE, w), {15'h0, v[0], b});
					m_st[`ASE_TAG_BIT] = v[0];
					go(word_minus_op, PTR_KEEP, DST_ACC, 0, 0, OPD_ACC, OPD_MEM, 2, AM_POSTDEC, 0, 0, 0);
					rd_chk(ad(`ASE_OFS_IDX_BASE, 2), 32'(2 * w - 2));
				end
				default: begin
					b = {8'h0, b[7:0]};
					go(minus_byte_op, PTR_KEEP, DST_ACC, 0, 0, OPD_ACC, OPD_IMM16, 0, AM_DIRECT, 0, b[7:0], 0);
				end
			endcase
			s = sub(a, b);
			flags(s[15:0], s[17], s[16]);
			rd_chk(ad(`ASE_OFS_ACC_BASE, dst), {16'h0, s[15:0]});
			check({16'h0, status_word}, {16'h0, m_st});
		end
		for (k = 0; k < 4; k++) begin
			v = $urandom;
			a = v[31:16];
			b = (k == 2) ? a : v[15:0];
			wr(ad(`ASE_OFS_IDX_BASE, 3), {16'h0, a});
			wr(ad(`ASE_OFS_IDX_BASE, 5), {16'h0, b});
			go(k[0] ? minus_byte_op : word_minus_op, PTR_KEEP, DST_INDEX, 0, 0, OPD_ACC, k[0] ? OPD_IMM16 : OPD_R5, 3,
				AM_DIRECT, 0, b[7:0], 0);
			s = sub(a, k[0] ? {8'h0, b[7:0]} : b);
			rd_chk(ad(`ASE_OFS_IDX_BASE, 3), {16'h0, s[15:0]});
			check({30'h0, index_flags}, {30'h0, s[15:0] == 16'h0, s[16]});
			check({16'h0, status_word}, {16'h0, m_st});
		end
		$display("test subtract done");
		w = $urandom_range(0, 63);
		a = $urandom;
		wr(ad(`ASE_OFS_RAM_BASE, w), {16'h0, a});
		go(set_marker_op, PTR_KEEP, DST_ACC, 0, 0, OPD_ACC, OPD_MEM, 0, AM_DIRECT, 16'(2 * w + 1), 0, 0);
		rd_chk(ad(`ASE_OFS_RAM_BASE, w), {15'h0, 1'b1, a});
		x = $urandom_range(0, 31);
		y = $urandom_range(0, 31);
		wr(ad(`ASE_OFS_RAM_BASE, x + y), {16'h0, ~a});
		wr(ad(`ASE_OFS_IDX_BASE, 1), 32'(2 * x));
		wr(ad(`ASE_OFS_IDX_BASE, 5), 32'(2 * y + 1));
		go(set_marker_op, PTR_KEEP, DST_ACC, 0, 0, OPD_ACC, OPD_MEM, 1, AM_INDEXED, 0, 0, 0);
		rd_chk(ad(`ASE_OFS_RAM_BASE, x + y), {15'h0, 1'b1, ~a});
		rd_chk(ad(`ASE_OFS_IDX_BASE, 1), 32'(2 * x));
		rd_chk(ad(`ASE_OFS_IDX_BASE, 5), 32'(2 * y + 1));
		check({16'h0, status_word}, {16'h0, m_st});
		$display("test marker done");
		m_st = 16'($urandom) & 16'h01F1;
		wr(`ASE_OFS_STATUS, {16'h0, m_st});
		go(set_saturation_op, PTR_KEEP, DST_ACC, 0, 0, OPD_ACC, OPD_ACC, 0, AM_DIRECT, 0, 0, 0);
		m_st[`ASE_OM_BIT] = 1'b1;
		check({16'h0, status_word}, {16'h0, m_st});
		wr(ad(`ASE_OFS_ACC_BASE, ap), {16'h0, `ASE_SAT_NEG});
		go(word_minus_op, PTR_KEEP, DST_ACC, 0, 0, OPD_ACC, OPD_IMM16, 0, AM_DIRECT, 16'h0001, 0, 0);
		rd_chk(ad(`ASE_OFS_ACC_BASE, ap), {16'h0, `ASE_SAT_NEG});
		$display("test saturation done");
		results();
	end
endmodule
